//--- src/mtb_button_ctrl.sv
// Purpose: momentary touch button table, touch hit detection and host notification
// Assumes: touch panel signals arrive from pins; command decoder and image engine run on clk_sys
// Notes: Functional notes
// Functional notes
// - button identifier must be 0 to 127
// - type 1: pressed image, notify press only
// - type 3: repeat press notification while held
// - type 30: repeats after first are silent
// - type 4: notify on release only
// - type 5: notify on press and release
// - press sends x, identifier, carriage return
// - release sends r, identifier, carriage return
// - redefining a button clears its macro assignment
// - label in foreground colour, code 10 breaks line
// - label placed at offsets from button corner
// - x and y give button top-left corner
// - touch may start the button's assigned macro
`timescale 1ns/100ps
`include "mtb_params.svh"
module mtb_button_ctrl
   import mtb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic define_button_cmd,
   input wire logic [7:0] def_id,
   input wire logic [`MTB_COORD_W-1:0] def_x,
   input wire logic [`MTB_COORD_W-1:0] def_y,
   input wire logic [7:0] def_type,
   input wire logic [`MTB_COORD_W-1:0] def_label_offset_x,
   input wire logic [`MTB_COORD_W-1:0] def_label_offset_y,
   input wire logic [`MTB_IMG_W-1:0] def_idle_image_index,
   input wire logic [`MTB_IMG_W-1:0] def_pressed_image_index,
   input wire logic [`MTB_COORD_W-1:0] def_image_w,
   input wire logic [`MTB_COORD_W-1:0] def_image_h,
   input wire logic macro_assign,
   input wire logic [7:0] macro_assign_id,
   input wire logic [`MTB_TCNT_W-1:0] typematic_delay,
   input wire logic [`MTB_TCNT_W-1:0] typematic_period,
   input wire logic [`MTB_COLOR_W-1:0] fg_color,
   input wire logic label_in_valid,
   input wire logic [7:0] label_in_char,
   input wire logic touch_down,
   input wire logic [`MTB_COORD_W-1:0] touch_x,
   input wire logic [`MTB_COORD_W-1:0] touch_y,
   output logic def_error,
   output logic draw_valid,
   output logic [`MTB_COORD_W-1:0] draw_x,
   output logic [`MTB_COORD_W-1:0] draw_y,
   output logic [`MTB_IMG_W-1:0] draw_image,
   output logic [`MTB_COORD_W-1:0] draw_label_x,
   output logic [`MTB_COORD_W-1:0] draw_label_y,
   output logic [`MTB_COLOR_W-1:0] draw_color,
   output logic label_out_valid,
   output logic [7:0] label_out_char,
   output logic label_newline,
   output logic macro_start,
   output logic [`MTB_ID_W-1:0] macro_id,
   output logic beep,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready
);
   typedef struct packed {
      mtb_state_t st;
      logic [`MTB_ID_W-1:0] idx;
      logic [`MTB_ID_W-1:0] act;
      logic [`MTB_TCNT_W-1:0] tcnt;
      logic note_req;
      logic note_rel;
      logic [`MTB_ID_W-1:0] note_id;
      logic down1;
      logic down2;
      logic [`MTB_COORD_W-1:0] tx1;
      logic [`MTB_COORD_W-1:0] tx2;
      logic [`MTB_COORD_W-1:0] ty1;
      logic [`MTB_COORD_W-1:0] ty2;
      logic def_error;
      logic draw_valid;
      logic [`MTB_COORD_W-1:0] draw_x;
      logic [`MTB_COORD_W-1:0] draw_y;
      logic [`MTB_IMG_W-1:0] draw_image;
      logic [`MTB_COORD_W-1:0] draw_label_x;
      logic [`MTB_COORD_W-1:0] draw_label_y;
      logic [`MTB_COLOR_W-1:0] draw_color;
      logic label_out_valid;
      logic [7:0] label_out_char;
      logic label_newline;
      logic macro_start;
      logic [`MTB_ID_W-1:0] macro_id;
      logic beep;
      mtb_entry_t [`MTB_NUM_BTN-1:0] tbl;
   } mtb_ctrl_reg_t;
   mtb_ctrl_reg_t s;
   mtb_ctrl_reg_t next_s;
   mtb_entry_t e;
   mtb_entry_t a;
   mtb_kind_t def_kind;
   logic def_kind_ok;
   logic hit;
   logic [`MTB_COORD_W:0] right;
   logic [`MTB_COORD_W:0] bottom;
   mtb_note_if note ();

   assign def_error = s.def_error;
   assign draw_valid = s.draw_valid;
   assign draw_x = s.draw_x;
   assign draw_y = s.draw_y;
   assign draw_image = s.draw_image;
   assign draw_label_x = s.draw_label_x;
   assign draw_label_y = s.draw_label_y;
   assign draw_color = s.draw_color;
   assign label_out_valid = s.label_out_valid;
   assign label_out_char = s.label_out_char;
   assign label_newline = s.label_newline;
   assign macro_start = s.macro_start;
   assign macro_id = s.macro_id;
   assign beep = s.beep;
   assign note.req = s.note_req;
   assign note.rel = s.note_rel;
   assign note.id = s.note_id;

   // scanned entry and the entry of the button being held
   assign e = s.tbl[s.idx];
   assign a = s.tbl[s.act];
   assign right = {1'b0, e.x} + {1'b0, e.w};
   assign bottom = {1'b0, e.y} + {1'b0, e.h};
   assign hit = e.defined && ({1'b0, s.tx2} >= {1'b0, e.x}) && ({1'b0, s.tx2} < right)
      && ({1'b0, s.ty2} >= {1'b0, e.y}) && ({1'b0, s.ty2} < bottom);

   // type code to kind; unknown codes refuse the definition
   always_comb
   begin
      def_kind = MTB_KIND_STD;
      def_kind_ok = 1'b1;
      case (def_type)
         `MTB_TYPE_STD: def_kind = MTB_KIND_STD;
         `MTB_TYPE_TYPEMATIC: def_kind = MTB_KIND_TYPEMATIC;
         `MTB_TYPE_TYPEMATIC_QUIET: def_kind = MTB_KIND_TYPEMATIC_QUIET;
         `MTB_TYPE_RELEASE: def_kind = MTB_KIND_RELEASE;
         `MTB_TYPE_BOTH: def_kind = MTB_KIND_BOTH;
         default: def_kind_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      next_s = s;
      next_s.def_error = 1'b0;
      next_s.draw_valid = 1'b0;
      next_s.label_out_valid = 1'b0;
      next_s.label_newline = 1'b0;
      next_s.macro_start = 1'b0;
      next_s.beep = 1'b0;
      // touch panel is asynchronous: two flops before anything looks at it
      next_s.down1 = touch_down;
      next_s.down2 = s.down1;
      next_s.tx1 = touch_x;
      next_s.tx2 = s.tx1;
      next_s.ty1 = touch_y;
      next_s.ty2 = s.ty1;
      // request leaves once the sender takes it
      if (s.note_req && note.ready)
      begin
         next_s.note_req = 1'b0;
      end
      // label bytes pass through; code 10 becomes a line break marker
      if (label_in_valid)
      begin
         next_s.label_out_valid = (label_in_char != `MTB_CHAR_NEWLINE);
         next_s.label_newline = (label_in_char == `MTB_CHAR_NEWLINE);
         next_s.label_out_char = label_in_char;
      end
      if (macro_assign && (macro_assign_id <= {1'b0, `MTB_ID_MAX}))
      begin
         next_s.tbl[macro_assign_id[`MTB_ID_W-1:0]].macro = 1'b1;
      end
      // definition: store entry and draw it idle; a later definition overrides a same-cycle assign
      if (define_button_cmd)
      begin
         if ((def_id > {1'b0, `MTB_ID_MAX}) || !def_kind_ok)
         begin
            next_s.def_error = 1'b1;
         end
         else
         begin
            next_s.tbl[def_id[`MTB_ID_W-1:0]] = '{defined: 1'b1, kind: def_kind, x: def_x, y: def_y,
               w: def_image_w, h: def_image_h, label_offset_x: def_label_offset_x,
               label_offset_y: def_label_offset_y, idle_image_index: def_idle_image_index,
               pressed_image_index: def_pressed_image_index, macro: 1'b0};
            next_s.draw_valid = 1'b1;
            next_s.draw_x = def_x;
            next_s.draw_y = def_y;
            next_s.draw_image = def_idle_image_index;
            next_s.draw_label_x = def_x + def_label_offset_x;
            next_s.draw_label_y = def_y + def_label_offset_y;
            next_s.draw_color = fg_color;
         end
      end
      // touch tracking; a new touch waits until any earlier string has been handed over
      case (s.st)
         MTB_ST_IDLE:
         begin
            if (s.down2 && !s.note_req)
            begin
               next_s.idx = '0;
               next_s.st = MTB_ST_SCAN;
            end
         end
         MTB_ST_SCAN:
         begin
            if (!s.down2)
            begin
               next_s.st = MTB_ST_IDLE;
            end
            else if (hit)
            begin
               next_s.act = s.idx;
               next_s.draw_valid = 1'b1;
               next_s.draw_x = e.x;
               next_s.draw_y = e.y;
               next_s.draw_image = e.pressed_image_index;
               next_s.draw_label_x = e.x + e.label_offset_x;
               next_s.draw_label_y = e.y + e.label_offset_y;
               next_s.draw_color = fg_color;
               if (e.kind != MTB_KIND_RELEASE)
               begin
                  next_s.note_req = 1'b1;
                  next_s.note_rel = 1'b0;
                  next_s.note_id = s.idx;
                  next_s.beep = 1'b1;
               end
               next_s.macro_start = e.macro;
               next_s.macro_id = s.idx;
               next_s.tcnt = typematic_delay;
               next_s.st = MTB_ST_HELD;
            end
            else if (s.idx == `MTB_ID_MAX)
            begin
               next_s.st = MTB_ST_NOMATCH;
            end
            else
            begin
               next_s.idx = s.idx + 7'h01;
            end
         end
         MTB_ST_HELD:
         begin
            if (!s.down2)
            begin
               // a pending string must go first so the release cannot overwrite it
               if (!s.note_req)
               begin
                  next_s.draw_valid = 1'b1;
                  next_s.draw_x = a.x;
                  next_s.draw_y = a.y;
                  next_s.draw_image = a.idle_image_index;
                  next_s.draw_label_x = a.x + a.label_offset_x;
                  next_s.draw_label_y = a.y + a.label_offset_y;
                  next_s.draw_color = fg_color;
                  if ((a.kind == MTB_KIND_RELEASE) || (a.kind == MTB_KIND_BOTH))
                  begin
                     next_s.note_req = 1'b1;
                     next_s.note_rel = 1'b1;
                     next_s.note_id = s.act;
                  end
                  next_s.st = MTB_ST_IDLE;
               end
            end
            else if ((a.kind == MTB_KIND_TYPEMATIC) || (a.kind == MTB_KIND_TYPEMATIC_QUIET))
            begin
               // repeats pace themselves; a slow host link stretches the period
               if (s.tcnt != '0)
               begin
                  next_s.tcnt = s.tcnt - 16'h0001;
               end
               else if (!s.note_req)
               begin
                  next_s.note_req = 1'b1;
                  next_s.note_rel = 1'b0;
                  next_s.note_id = s.act;
                  next_s.beep = (a.kind == MTB_KIND_TYPEMATIC);
                  next_s.tcnt = typematic_period;
               end
            end
         end
         default:
         begin
            if (!s.down2)
            begin
               next_s.st = MTB_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   mtb_note_tx u_note_tx (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .note(note),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_ready(tx_ready)
   );
endmodule

//--- src/mtb_note_if.sv
// Purpose: carries one notification request from the button logic to the string sender
// Assumes: both ends on clk_sys
// Notes: request taken when req and ready are both high
`timescale 1ns/100ps
`include "mtb_params.svh"
interface mtb_note_if;
   logic req;
   logic rel;
   logic [`MTB_ID_W-1:0] id;
   logic ready;
   modport src (output req, output rel, output id, input ready);
   modport snk (input req, input rel, input id, output ready);
endinterface

//--- src/mtb_note_tx.sv
// Purpose: turns a notification request into the byte string letter, decimal id, carriage return
// Assumes: byte sink uses valid/ready on clk_sys
// Notes: one request at a time; ready low while a string is going out
`timescale 1ns/100ps
`include "mtb_params.svh"
module mtb_note_tx
   import mtb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   mtb_note_if.snk note,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready
);
   typedef struct packed {
      mtb_tx_state_t st;
      logic rel;
      logic [3:0] hund;
      logic [3:0] tens;
      logic [3:0] ones;
      logic valid;
      logic [7:0] data;
   } mtb_tx_reg_t;
   mtb_tx_reg_t s;
   mtb_tx_reg_t next_s;
   logic [`MTB_ID_W-1:0] rem;
   logic [`MTB_ID_W-1:0] quo;

   assign note.ready = (s.st == MTB_TX_IDLE);
   assign tx_valid = s.valid;
   assign tx_data = s.data;
   // digit split of the identifier; at most 127 so the hundreds digit is 0 or 1
   assign rem = (note.id >= `MTB_HUNDRED) ? note.id - `MTB_HUNDRED : note.id;
   assign quo = rem / `MTB_TEN;

   // one byte is held until the sink takes it, then the next one is loaded
   always_comb
   begin
      next_s = s;
      if (s.st == MTB_TX_IDLE)
      begin
         if (note.req)
         begin
            next_s.rel = note.rel;
            next_s.hund = {3'h0, note.id >= `MTB_HUNDRED};
            next_s.tens = quo[3:0];
            next_s.ones = 4'(rem - 7'(quo * `MTB_TEN));
            next_s.valid = 1'b1;
            next_s.data = note.rel ? `MTB_CHAR_RELEASE : `MTB_CHAR_PRESS;
            next_s.st = MTB_TX_LETTER;
         end
      end
      else if (s.valid && tx_ready)
      begin
         case (s.st)
            MTB_TX_LETTER:
            begin
               // no leading zeros: skip digits that would only be zero padding
               if (s.hund != 4'h0)
               begin
                  next_s.data = `MTB_CHAR_ZERO + {4'h0, s.hund};
                  next_s.st = MTB_TX_HUND;
               end
               else if (s.tens != 4'h0)
               begin
                  next_s.data = `MTB_CHAR_ZERO + {4'h0, s.tens};
                  next_s.st = MTB_TX_TENS;
               end
               else
               begin
                  next_s.data = `MTB_CHAR_ZERO + {4'h0, s.ones};
                  next_s.st = MTB_TX_ONES;
               end
            end
            MTB_TX_HUND:
            begin
               next_s.data = `MTB_CHAR_ZERO + {4'h0, s.tens};
               next_s.st = MTB_TX_TENS;
            end
            MTB_TX_TENS:
            begin
               next_s.data = `MTB_CHAR_ZERO + {4'h0, s.ones};
               next_s.st = MTB_TX_ONES;
            end
            MTB_TX_ONES:
            begin
               next_s.data = `MTB_CHAR_CR;
               next_s.st = MTB_TX_CR;
            end
            default:
            begin
               next_s.valid = 1'b0;
               next_s.data = 8'h00;
               next_s.st = MTB_TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end
endmodule

//--- src/mtb_params.svh
// Purpose: constants for the momentary touch button block
// Assumes: included by the package and by every design file that needs a figure
// Notes: definitions only
`ifndef MTB_PARAMS_SVH
`define MTB_PARAMS_SVH
`define MTB_NUM_BTN 128
`define MTB_ID_W 7
`define MTB_ID_MAX 7'h7f
`define MTB_COORD_W 10
`define MTB_IMG_W 8
`define MTB_COLOR_W 16
`define MTB_TCNT_W 16
`define MTB_TYPE_STD 8'h01
`define MTB_TYPE_TYPEMATIC 8'h03
`define MTB_TYPE_TYPEMATIC_QUIET 8'h1e
`define MTB_TYPE_RELEASE 8'h04
`define MTB_TYPE_BOTH 8'h05
`define MTB_CHAR_PRESS 8'h78
`define MTB_CHAR_RELEASE 8'h72
`define MTB_CHAR_CR 8'h0d
`define MTB_CHAR_NEWLINE 8'h0a
`define MTB_CHAR_ZERO 8'h30
`define MTB_HUNDRED 7'h64
`define MTB_TEN 7'h0a
`endif

//--- src/mtb_pkg.sv
// Purpose: shared types of the momentary touch button block
// Assumes: mtb_params.svh gives the widths
// Notes: types only
`include "mtb_params.svh"
package mtb_pkg;
   typedef enum logic [2:0] {MTB_KIND_STD, MTB_KIND_TYPEMATIC, MTB_KIND_TYPEMATIC_QUIET,
      MTB_KIND_RELEASE, MTB_KIND_BOTH} mtb_kind_t;
   typedef struct packed {
      logic defined;
      mtb_kind_t kind;
      logic [`MTB_COORD_W-1:0] x;
      logic [`MTB_COORD_W-1:0] y;
      logic [`MTB_COORD_W-1:0] w;
      logic [`MTB_COORD_W-1:0] h;
      logic [`MTB_COORD_W-1:0] label_offset_x;
      logic [`MTB_COORD_W-1:0] label_offset_y;
      logic [`MTB_IMG_W-1:0] idle_image_index;
      logic [`MTB_IMG_W-1:0] pressed_image_index;
      logic macro;
   } mtb_entry_t;
   typedef enum logic [2:0] {MTB_ST_IDLE, MTB_ST_SCAN, MTB_ST_HELD, MTB_ST_NOMATCH} mtb_state_t;
   typedef enum logic [2:0] {MTB_TX_IDLE, MTB_TX_LETTER, MTB_TX_HUND, MTB_TX_TENS, MTB_TX_ONES,
      MTB_TX_CR} mtb_tx_state_t;
endpackage

//--- testbench/mtb_button_ctrl_properties.sv
// Purpose: port assertions for the momentary touch button block
// Assumes: one clk_sys domain, sys_rst synchronous and active high
// Notes: bound onto mtb_button_ctrl, sees only its ports
`timescale 1ns/100ps
module mtb_button_ctrl_properties
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic define_button_cmd,
   input wire logic [7:0] def_id,
   input wire logic [7:0] def_type,
   input wire logic label_in_valid,
   input wire logic [7:0] label_in_char,
   input wire logic def_error,
   input wire logic draw_valid,
   input wire logic label_out_valid,
   input wire logic [7:0] label_out_char,
   input wire logic label_newline,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready
);
   logic [7:0] last_tx;
   logic [7:0] last_tx2;
   // last two bytes the host took; a lone zero digit is only legal right after the letter
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         last_tx <= 8'h00;
         last_tx2 <= 8'h00;
      end
      else if (tx_valid && tx_ready)
      begin
         last_tx <= tx_data;
         last_tx2 <= last_tx;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_good_def;
      define_button_cmd && def_id <= 8'h7f && def_type inside {8'h01, 8'h03, 8'h1e, 8'h04, 8'h05};
   endsequence
   sequence s_letter_taken;
      tx_valid && tx_ready && (tx_data == 8'h78 || tx_data == 8'h72);
   endsequence
   a_def_refused: assert property (define_button_cmd && (def_id > 8'h7f ||
      !(def_type inside {8'h01, 8'h03, 8'h1e, 8'h04, 8'h05})) |=> def_error)
      else $error("bad define not refused");
   a_def_drawn: assert property (s_good_def |=> draw_valid && !def_error)
      else $error("good define not drawn");
   a_label_pass: assert property (label_in_valid && label_in_char != 8'h0a |=>
      label_out_valid && !label_newline && label_out_char == $past(label_in_char))
      else $error("label byte not passed");
   a_label_break: assert property (label_in_valid && label_in_char == 8'h0a |=> label_newline)
      else $error("newline not flagged");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("host byte dropped before taken");
   a_first_letter: assert property ($rose(tx_valid) |-> tx_data == 8'h78 || tx_data == 8'h72)
      else $error("string does not start with letter");
   a_digit_next: assert property (s_letter_taken |=> tx_valid && tx_data inside {[8'h30:8'h39]})
      else $error("no digit after letter");
   a_no_lead_zero: assert property (tx_valid && tx_ready && last_tx == 8'h30 &&
      (last_tx2 == 8'h78 || last_tx2 == 8'h72) |-> tx_data == 8'h0d)
      else $error("leading zero in identifier");
   a_cr_ends: assert property (tx_valid && tx_ready && tx_data == 8'h0d |=> !tx_valid)
      else $error("sender busy after carriage return");
endmodule
bind mtb_button_ctrl mtb_button_ctrl_properties u_props (.clk_sys, .sys_rst, .define_button_cmd, .def_id,
   .def_type, .label_in_valid, .label_in_char, .def_error, .draw_valid, .label_out_valid, .label_out_char,
   .label_newline, .tx_valid, .tx_data, .tx_ready);

//--- testbench/mtb_button_ctrl_tb_top.sv
// Purpose: self-checking bench for the momentary touch button block
// Assumes: host sink model on the byte link, inputs driven at the falling edge
// Notes: fixed-seed lfsr draws offsets, images, colours, label bytes and host stalls
`timescale 1ns/100ps
`include "mtb_params.svh"
module mtb_button_ctrl_tb_top;
   logic clk_sys, sys_rst, define_button_cmd, macro_assign, label_in_valid, touch_down, stall;
   logic [7:0] def_id, def_type, macro_assign_id, label_in_char, label_out_char, tx_data, got_data;
   logic [9:0] def_x, def_y, def_label_offset_x, def_label_offset_y, def_image_w, def_image_h;
   logic [9:0] touch_x, touch_y, draw_x, draw_y, draw_label_x, draw_label_y;
   logic [7:0] def_idle_image_index, def_pressed_image_index, draw_image;
   logic [15:0] typematic_delay, typematic_period, fg_color, draw_color;
   logic def_error, draw_valid, label_out_valid, label_newline, macro_start, beep, tx_valid, tx_ready, got;
   logic [6:0] macro_id, last_macro;
   logic [31:0] lfsr_state, stall_state;
   logic [7:0] bid [5] = '{8'h00, 8'h17, 8'h7f, 8'h05, 8'h40};
   logic [7:0] btype [5] = '{8'h01, 8'h03, 8'h1e, 8'h04, 8'h05};
   logic [7:0] idle [5];
   logic [9:0] offs [5];
   logic [7:0] rx_q [$];
   int n_mismatch, checks_done, n_beep, n_macro, cycles;

   mtb_button_ctrl uut (.clk_sys, .sys_rst, .define_button_cmd, .def_id, .def_x, .def_y, .def_type,
      .def_label_offset_x, .def_label_offset_y, .def_idle_image_index, .def_pressed_image_index,
      .def_image_w, .def_image_h, .macro_assign, .macro_assign_id, .typematic_delay, .typematic_period,
      .fg_color, .label_in_valid, .label_in_char, .touch_down, .touch_x, .touch_y, .def_error, .draw_valid,
      .draw_x, .draw_y, .draw_image, .draw_label_x, .draw_label_y, .draw_color, .label_out_valid,
      .label_out_char, .label_newline, .macro_start, .macro_id, .beep, .tx_valid, .tx_data, .tx_ready);
   mtb_host_sink u_host (.clk_sys, .sys_rst, .stall, .tx_valid, .tx_data, .tx_ready, .got, .got_data);

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected beeps: first press of 1, 3, 5, 30 and every repeat of 3
   function automatic int exp_beeps(input logic [7:0] ty, input int reps);
      return (ty == 8'h03) ? reps : (ty == 8'h04) ? 0 : 1;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // i selects the slot: button i sits at x=120*i+5, y=50, all images 20x20
   task automatic define_btn(input int i, input logic [7:0] id, input logic [7:0] ty, input logic ok);
      @(negedge clk_sys);
      lfsr_state = lfsr_next(lfsr_state);
      // a refused define leaves the table alone, so the slot's expectations must stay too
      if (ok)
      begin
         offs[i] = {6'h00, lfsr_state[3:0]};
         idle[i] = lfsr_state[15:8];
      end
      define_button_cmd = 1'b1;
      def_id = id;
      def_type = ty;
      def_x = 10'(120 * i + 5);
      def_label_offset_x = offs[i];
      def_label_offset_y = offs[i] + 10'h001;
      def_idle_image_index = idle[i];
      def_pressed_image_index = ~idle[i];
      fg_color = lfsr_state[31:16];
      @(negedge clk_sys);
      define_button_cmd = 1'b0;
      if (ok)
      begin
         check(draw_image, idle[i]);
         check(draw_x, def_x);
         check(draw_y, 10'h032);
         check(draw_label_x, def_x + offs[i]);
         check(draw_label_y, 10'h033 + offs[i]);
         check(draw_color, fg_color);
      end
      else
         check(def_error, 1'b1);
   endtask

   // touch slot i for hold cycles, release, then judge the strings the host got
   task automatic touch_btn(input int i, input int hold, input int mac);
      string xs, rs, es;
      int reps;
      xs = $sformatf("x%0d%c", bid[i], 8'h0d);
      rs = $sformatf("r%0d%c", bid[i], 8'h0d);
      rx_q = {};
      n_beep = 0;
      n_macro = 0;
      @(negedge clk_sys);
      touch_x = 10'(120 * i + 8);
      touch_down = 1'b1;
      repeat (hold) @(negedge clk_sys);
      check(draw_image, 8'(~idle[i]));
      touch_down = 1'b0;
      repeat (60) @(negedge clk_sys);
      check(draw_image, idle[i]);
      reps = rx_q.size() / xs.len();
      case (btype[i])
         8'h01: es = xs;
         8'h04: es = rs;
         8'h05: es = {xs, rs};
         default:
         begin
            check(reps >= 2, 1);
            es = "";
            repeat (reps) es = {es, xs};
         end
      endcase
      check(rx_q.size(), es.len());
      foreach (rx_q[j])
         if (j < es.len())
            check(rx_q[j], es.getc(j));
      check(n_beep, exp_beeps(btype[i], reps));
      check(n_macro, mac);
      if (mac != 0)
         check(last_macro, bid[i][6:0]);
   endtask

   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;

   // host stall pattern, drawn off the sampling edge
   always @(negedge clk_sys)
   begin
      stall_state = lfsr_next(stall_state);
      stall <= stall_state[0] & stall_state[1];
   end

   // collect host bytes, beeps and macro starts; cut a hang short
   always @(posedge clk_sys)
   begin
      cycles++;
      if (got)
         rx_q.push_back(got_data);
      if (beep)
         n_beep++;
      if (macro_start)
      begin
         n_macro++;
         last_macro = macro_id;
      end
      if (cycles == 10000)
      begin
         n_mismatch++;
         print_verdict;
      end
   end

   initial
   begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      {define_button_cmd, macro_assign, label_in_valid, touch_down, stall} = 5'h00;
      {def_id, def_type, macro_assign_id, label_in_char} = 32'h00000000;
      {def_x, def_label_offset_x, def_label_offset_y, touch_x} = 40'h0000000000;
      def_y = 10'h032;
      touch_y = 10'h035;
      def_image_w = 10'h014; // both images one size
      def_image_h = 10'h014;
      {def_idle_image_index, def_pressed_image_index, fg_color} = 32'h00000000;
      typematic_delay = 16'h0014;
      typematic_period = 16'h000f;
      lfsr_state = 32'h83ae;
      stall_state = 32'h83ae ^ 32'h00005a5a;
      repeat (6) @(negedge clk_sys);
      sys_rst = 1'b0;
      for (int i = 0; i < 5; i++)
         define_btn(i, bid[i], btype[i], 1'b1); // ids kept within 0..127
      define_btn(4, 8'h80, 8'h01, 1'b0);
      define_btn(4, 8'h0a, 8'h02, 1'b0);
      // label bytes pass straight through, one of them a line break
      for (int j = 0; j < 6; j++)
      begin
         lfsr_state = lfsr_next(lfsr_state);
         label_in_valid = 1'b1;
         label_in_char = (j == 2) ? 8'h0a : {1'b0, lfsr_state[6:0]};
         @(negedge clk_sys);
         label_in_valid = 1'b0;
         check(label_newline, label_in_char == 8'h0a);
         check(label_out_valid, label_in_char != 8'h0a);
         if (label_in_char != 8'h0a)
            check(label_out_char, label_in_char);
      end
      for (int i = 0; i < 5; i++)
         touch_btn(i, 200, 0);
      macro_assign = 1'b1;
      macro_assign_id = 8'h17; // non-zero id so the reported macro id can really be wrong
      @(negedge clk_sys);
      macro_assign = 1'b0;
      touch_btn(1, 200, 1);
      define_btn(1, bid[1], btype[1], 1'b1);
      touch_btn(1, 200, 0);
      print_verdict;
   end
endmodule

//--- testbench/mtb_host_sink.sv
// Purpose: host end of the notification byte link
// Assumes: stall is drawn by the bench off the sampling edge
// Notes: ready only moves just after a rising edge
`timescale 1ns/100ps
module mtb_host_sink
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic got,
   output logic [7:0] got_data
);
   // a stalling host is legal, so the sender must hold its byte
   always_ff @(posedge clk_sys)
      tx_ready <= !sys_rst && !stall;
   // a byte counts as delivered only on a handshake edge
   assign got = tx_valid && tx_ready;
   assign got_data = tx_data;
endmodule
